// file: core/pfwp_host.sv
// host-side controller that reads and word-programs the parallel flash
// assumes the flash answers on data_pins inside ACCESS_CYC of both enables low
`timescale 1ns/1ps
module pfwp_host (
	// clock and control
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	// user request side
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_abort,
	input wire logic wp_hold_n,
	input wire pfwp_pkg::pfwp_word_t req_word,
	output logic req_ready,
	output logic rsp_valid,
	output logic [pfwp_pkg::DATA_W-1:0] rsp_data,
	output logic prog_timeout,
	// flash pins
	output logic [pfwp_pkg::ADDR_W-1:0] top_address_line,
	output pfwp_pkg::pfwp_ctl_t flash_ctl,
	input wire logic [pfwp_pkg::DATA_W-1:0] data_pins_in,
	output logic [pfwp_pkg::DATA_W-1:0] data_pins_out,
	output logic data_pins_oe
);
	pfwp_pkg::pfwp_state_t st_reg, st_next;
	pfwp_pkg::pfwp_word_t word_reg, word_next;
	pfwp_pkg::pfwp_ctl_t ctl_reg, ctl_next;
	logic [pfwp_pkg::ADDR_W-1:0] addr_reg, addr_next;
	logic [pfwp_pkg::DATA_W-1:0] dout_reg, dout_next, rdat_reg, rdat_next;
	logic [pfwp_pkg::DATA_W-1:0] prev_reg, prev_next;
	logic oe_reg, oe_next, wr_reg, wr_next, poll_reg, poll_next;
	logic rv_reg, rv_next, to_reg, to_next, first_reg, first_next;
	logic rdy_reg, rdy_next;
	logic [1:0] wcnt_reg, wcnt_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [pfwp_pkg::CNT_W-1:0] pt_reg, pt_next;
	logic [pfwp_pkg::DATA_W-1:0] din_s1, din_s2;

	// two-flop sync of the pins; first stage feeds only the second
	always_ff @(posedge ref_clk) begin
		if (clk_en) begin
			din_s1 <= data_pins_in;
			din_s2 <= din_s1;
		end
	end

	// one write cycle: pick the word for the current step of the sequence
	function automatic pfwp_pkg::pfwp_word_t seq_word(input logic [1:0] n,
		input pfwp_pkg::pfwp_word_t w);
		pfwp_pkg::pfwp_word_t r;
		r = w;
		unique case (n)
			2'h0: r = '{pfwp_pkg::UNLOCK_A1, pfwp_pkg::UNLOCK_D1};
			2'h1: r = '{pfwp_pkg::UNLOCK_A2, pfwp_pkg::UNLOCK_D2};
			2'h2: r = '{pfwp_pkg::UNLOCK_A1, pfwp_pkg::PROG_CMD};
			2'h3: r = w;
		endcase
		return r;
	endfunction

	// next-state logic for the pin sequencer
	always_comb begin
		st_next = st_reg;
		word_next = word_reg;
		ctl_next = ctl_reg;
		addr_next = addr_reg;
		dout_next = dout_reg;
		rdat_next = rdat_reg;
		prev_next = prev_reg;
		oe_next = oe_reg;
		wr_next = wr_reg;
		poll_next = poll_reg;
		rv_next = 1'b0;
		to_next = to_reg;
		first_next = first_reg;
		wcnt_next = wcnt_reg;
		cnt_next = (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
		pt_next = (pt_reg != '0) ? pt_reg - 10'h001 : '0;
		ctl_next.wr_prot_n = (st_reg == pfwp_pkg::PFWP_IDLE) ?
			wp_hold_n : ctl_reg.wr_prot_n; // steady through a sequence
		unique case (st_reg)
			pfwp_pkg::PFWP_IDLE: begin
				if (req_valid) begin
					word_next = req_word;
					wr_next = req_write;
					wcnt_next = 2'h0;
					to_next = 1'b0;
					if (req_write) begin
						// flash sector must already be blank
						{addr_next, dout_next} = seq_word(2'h0, req_word);
						oe_next = 1'b1;
						st_next = pfwp_pkg::PFWP_WSET;
					end else begin
						addr_next = req_word.addr;
						oe_next = 1'b0;
						st_next = pfwp_pkg::PFWP_RLOW;
						ctl_next.chip_sel_n = 1'b0; // both low to read
						ctl_next.out_gate_n = 1'b0;
					end
					// a read waits the access time plus the two sync stages
					cnt_next = req_write ? pfwp_pkg::SETUP_CYC :
						pfwp_pkg::ACCESS_CYC + 4'h2;
				end
			end
			pfwp_pkg::PFWP_WSET: begin
				// address settles, then select and strobe drop
				ctl_next.out_gate_n = 1'b1;
				ctl_next.chip_sel_n = 1'b0;
				if (cnt_reg == 4'h0) begin
					ctl_next.wr_strobe_n = 1'b0;
					cnt_next = pfwp_pkg::STROBE_CYC;
					st_next = pfwp_pkg::PFWP_WLOW;
				end
			end
			pfwp_pkg::PFWP_WLOW: begin
				// strobe rises first, data stays held past it
				if (cnt_reg == 4'h0) begin
					ctl_next.wr_strobe_n = 1'b1;
					cnt_next = pfwp_pkg::SETUP_CYC;
					st_next = pfwp_pkg::PFWP_WHOLD;
				end
			end
			pfwp_pkg::PFWP_WHOLD: begin
				if (cnt_reg == 4'h0) begin
					ctl_next.chip_sel_n = 1'b1; // deselect between writes
					oe_next = 1'b0;
					if (wcnt_reg == pfwp_pkg::WR_LAST) begin
						// program runs; no writes until done
						pt_next = pfwp_pkg::PROG_CYC;
						first_next = 1'b1;
						cnt_next = pfwp_pkg::SETUP_CYC;
						st_next = pfwp_pkg::PFWP_POLL;
					end else begin
						wcnt_next = wcnt_reg + 2'h1;
						{addr_next, dout_next} = seq_word(wcnt_reg + 2'h1,
							word_reg);
						oe_next = 1'b1;
						cnt_next = pfwp_pkg::SETUP_CYC;
						st_next = pfwp_pkg::PFWP_WSET;
					end
				end
			end
			pfwp_pkg::PFWP_POLL: begin
				// status read at the target address
				if (cnt_reg == 4'h0) begin
					addr_next = word_reg.addr;
					ctl_next.chip_sel_n = 1'b0;
					ctl_next.out_gate_n = 1'b0;
					// din_s2 lags the pins by two edges, so wait them out
					cnt_next = pfwp_pkg::ACCESS_CYC + 4'h2;
					poll_next = 1'b1;
					st_next = pfwp_pkg::PFWP_RLOW;
				end
			end
			pfwp_pkg::PFWP_RLOW: begin
				if (cnt_reg == 4'h0 && !(st_reg == pfwp_pkg::PFWP_RLOW &&
					ctl_reg.chip_sel_n)) begin
					rdat_next = din_s2;
					ctl_next.chip_sel_n = 1'b1; // release bus
					ctl_next.out_gate_n = 1'b1;
					st_next = pfwp_pkg::PFWP_RDONE;
				end
			end
			pfwp_pkg::PFWP_RDONE: begin
				if (!poll_reg) begin
					rv_next = 1'b1;
					st_next = pfwp_pkg::PFWP_IDLE;
				end else if (rdat_reg[pfwp_pkg::POLL_BIT] ==
					word_reg.data[pfwp_pkg::POLL_BIT] && !first_reg &&
					rdat_reg[pfwp_pkg::TOGGLE_BIT] ==
					prev_reg[pfwp_pkg::TOGGLE_BIT]) begin
					// true data and toggle stopped: program done
					poll_next = 1'b0;
					rv_next = 1'b1;
					st_next = pfwp_pkg::PFWP_IDLE;
				end else if (pt_reg == '0) begin
					// overran the bounded program time
					to_next = 1'b1;
					poll_next = 1'b0;
					rv_next = 1'b1;
					st_next = pfwp_pkg::PFWP_RST;
					ctl_next.reset_n = 1'b0;
					cnt_next = pfwp_pkg::STROBE_CYC;
				end else begin
					prev_next = rdat_reg;
					first_next = 1'b0;
					cnt_next = pfwp_pkg::SETUP_CYC;
					st_next = pfwp_pkg::PFWP_POLL;
				end
			end
			pfwp_pkg::PFWP_RST: begin
				// pulse the reset pin to put the device back in read
				if (cnt_reg == 4'h0) begin
					ctl_next.reset_n = 1'b1;
					st_next = pfwp_pkg::PFWP_IDLE;
				end
			end
		endcase
		if (req_abort && st_reg != pfwp_pkg::PFWP_RST) begin
			ctl_next = '{1'b1, 1'b1, 1'b1, 1'b0, ctl_reg.wr_prot_n};
			oe_next = 1'b0;
			poll_next = 1'b0;
			cnt_next = pfwp_pkg::STROBE_CYC;
			st_next = pfwp_pkg::PFWP_RST;
		end
		// ready is registered from the next state so the port is a flop
		rdy_next = (st_next == pfwp_pkg::PFWP_IDLE);
	end

	// register stage; clock enable freezes everything
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_reg <= pfwp_pkg::PFWP_IDLE;
			word_reg <= '0;
			ctl_reg <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
			addr_reg <= '0;
			dout_reg <= '0;
			rdat_reg <= '0;
			prev_reg <= '0;
			oe_reg <= 1'b0;
			wr_reg <= 1'b0;
			poll_reg <= 1'b0;
			rv_reg <= 1'b0;
			to_reg <= 1'b0;
			first_reg <= 1'b0;
			wcnt_reg <= 2'h0;
			cnt_reg <= 4'h0;
			pt_reg <= '0;
			rdy_reg <= 1'b1;
		end else if (clk_en) begin
			st_reg <= st_next;
			word_reg <= word_next;
			ctl_reg <= ctl_next;
			addr_reg <= addr_next;
			dout_reg <= dout_next;
			rdat_reg <= rdat_next;
			prev_reg <= prev_next;
			oe_reg <= oe_next;
			wr_reg <= wr_next;
			poll_reg <= poll_next;
			rv_reg <= rv_next;
			to_reg <= to_next;
			first_reg <= first_next;
			wcnt_reg <= wcnt_next;
			cnt_reg <= cnt_next;
			pt_reg <= pt_next;
			rdy_reg <= rdy_next;
		end
	end

	// outputs straight from flops
	assign req_ready = rdy_reg;
	assign rsp_valid = rv_reg;
	assign rsp_data = rdat_reg;
	assign prog_timeout = to_reg;
	assign top_address_line = addr_reg;
	assign flash_ctl = ctl_reg;
	assign data_pins_out = dout_reg;
	assign data_pins_oe = oe_reg;

	// never drive data while the device may drive it
	AST_NO_CONTENTION: assert property (@(posedge ref_clk) disable iff (reset)
		!(data_pins_oe && !flash_ctl.out_gate_n))
		else $error("data driven while output gate low");
	// write strobe only falls with chip select low
	AST_WR_WITH_SEL: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(flash_ctl.wr_strobe_n) |-> !flash_ctl.chip_sel_n)
		else $error("write strobe without chip select");
	// data held through the rising strobe edge
	AST_DATA_HELD: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(flash_ctl.wr_strobe_n) |-> data_pins_oe &&
		$stable(data_pins_out) && !flash_ctl.chip_sel_n)
		else $error("write data not held at strobe rise");
	// no write strobe while polling a running program
	AST_NO_CMD_IN_PROG: assert property (@(posedge ref_clk)
		disable iff (reset)
		poll_reg |-> flash_ctl.wr_strobe_n)
		else $error("command issued during program");
	// write protect steady during a sequence
	AST_WP_STEADY: assert property (@(posedge ref_clk) disable iff (reset)
		(st_reg != pfwp_pkg::PFWP_IDLE && clk_en) |=>
		$stable(flash_ctl.wr_prot_n))
		else $error("write protect moved mid-sequence");
	// output gate never opens on an unselected device
	AST_GATE_WITH_SEL: assert property (@(posedge ref_clk)
		disable iff (reset)
		!flash_ctl.out_gate_n |-> !flash_ctl.chip_sel_n)
		else $error("output gate low without chip select");
	// a program overrun always comes with a reset pin pulse
	AST_TIMEOUT_PULSE: assert property (@(posedge ref_clk)
		disable iff (reset)
		$rose(prog_timeout) |-> !flash_ctl.reset_n)
		else $error("timeout without reset pulse");
endmodule

// file: core/pfwp_pkg.sv
// constants and carrier types for the parallel flash word-program host
// assumes a 50 MHz ref_clk; the flash sits on plain pins outside this clock
package pfwp_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int CLK_MHZ = 50;
	// pin timing in ns (program time in us), and the cycle counts derived from them (rounded up)
	localparam int T_STROBE_NS = 40;
	localparam int T_ACCESS_NS = 80;
	localparam int T_SETUP_NS = 20;
	localparam int T_PROG_US = 10;
	localparam logic [3:0] STROBE_CYC = 4'((T_STROBE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] ACCESS_CYC = 4'((T_ACCESS_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [9:0] PROG_CYC = 10'(T_PROG_US * CLK_MHZ);
	localparam int CNT_W = 10;
	// unlock sequence
	localparam logic [ADDR_W-1:0] UNLOCK_A1 = 21'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK_A2 = 21'h0002AA;
	localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00AA;
	localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
	localparam logic [DATA_W-1:0] PROG_CMD = 16'h00A0;
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam logic [1:0] WR_LAST = 2'h3;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} pfwp_word_t;

	// flash pins driven by the host
	typedef struct packed {
		logic chip_sel_n;
		logic out_gate_n;
		logic wr_strobe_n;
		logic reset_n;
		logic wr_prot_n;
	} pfwp_ctl_t;

	typedef enum logic [2:0] {
		PFWP_IDLE = 3'h0,
		PFWP_WSET = 3'h1,
		PFWP_WLOW = 3'h3,
		PFWP_WHOLD = 3'h2,
		PFWP_POLL = 3'h6,
		PFWP_RLOW = 3'h7,
		PFWP_RDONE = 3'h5,
		PFWP_RST = 3'h4
	} pfwp_state_t;
endpackage

// file: tb/parallel_flash_word_program_tb.sv
// self-checking bench for the flash word-program host against a device model
// assumes pfwp_pkg and pfwp_host are compiled first
`timescale 1ns/1ps
module parallel_flash_word_program_tb;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic req_abort = 1'b0;
	logic wp_hold_n = 1'b1;
	pfwp_pkg::pfwp_word_t req_word = '0;
	logic req_ready, rsp_valid, prog_timeout, data_pins_oe;
	logic [15:0] rsp_data, data_pins_out, fl_dout, pins, q;
	logic [20:0] top_address_line;
	pfwp_pkg::pfwp_ctl_t flash_ctl;
	int n_errors = 0;
	int cmp_count = 0;
	always #10 ref_clk = ~ref_clk;
	// host drive wins, otherwise the model's level
	assign pins = data_pins_oe ? data_pins_out : fl_dout;
	pfwp_host dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
		.req_valid(req_valid), .req_write(req_write), .req_abort(req_abort),
		.wp_hold_n(wp_hold_n), .req_word(req_word), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.prog_timeout(prog_timeout), .top_address_line(top_address_line),
		.flash_ctl(flash_ctl), .data_pins_in(pins),
		.data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
	pfwp_flash_model fl (.addr(top_address_line), .ctl(flash_ctl),
		.pins(pins), .dout(fl_dout));
	task automatic check(input logic [15:0] got, exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic finish_test;
		if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// pin discipline watched on every falling edge out of reset; protect only while busy
	always @(negedge ref_clk) begin
		if (!reset && !flash_ctl.wr_strobe_n)
			check(flash_ctl.chip_sel_n, 1'b0, "strobe unselected");
		if (!reset)
			check(data_pins_oe & ~flash_ctl.out_gate_n, 1'b0, "clash");
		if (!reset && !req_ready)
			check(flash_ctl.wr_prot_n, wp_hold_n, "protect moved");
	end
	// one request, optionally frozen by clk_en right after it is taken
	task automatic do_req(input logic wr, input logic [20:0] a,
		input logic [15:0] d, input logic fz);
		int n;
		@(negedge ref_clk);
		req_valid = 1'b1;
		req_write = wr;
		req_word = {a, d};
		n = 0;
		// hold the request until an idle host will take it
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		@(negedge ref_clk);
		req_valid = 1'b0;
		if (fz) begin
			clk_en = 1'b0;
			repeat (5) @(negedge ref_clk);
			check(flash_ctl.chip_sel_n, 1'b0, "select lost in freeze");
			clk_en = 1'b1;
		end
		n = 0;
		while (rsp_valid !== 1'b1 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		q = rsp_data;
		check(n < 2000, 1'b1, "no response");
	endtask
	task automatic t_program(input logic [20:0] a, input logic [15:0] d);
		int n0;
		n0 = fl.n_wr;
		do_req(1'b1, a, d, 1'b0);
		check(prog_timeout, 1'b0, "program timed out");
		check(16'(fl.n_wr - n0), 16'h0004, "write count");
		check(16'(fl.n_bad), 16'h0000, "bad unlock");
		do_req(1'b0, a, 16'h0000, 1'b0);
		check(q, d, "read back");
	endtask
	task automatic t_protect;
		int p0;
		p0 = fl.n_prog;
		wp_hold_n = 1'b0;
		do_req(1'b1, 21'h000100, 16'h12C3, 1'b0);
		check(16'(fl.n_prog - p0), 16'h0000, "boot block programmed");
		do_req(1'b0, 21'h000100, 16'h0000, 1'b0);
		check(q, 16'hFFFF, "boot word changed");
		wp_hold_n = 1'b1;
	endtask
	task automatic t_abort;
		int n;
		@(negedge ref_clk);
		req_valid = 1'b1;
		req_write = 1'b1;
		req_word = {21'h0F0F0F, 16'h0000};
		@(negedge ref_clk);
		req_valid = 1'b0;
		repeat (45) @(negedge ref_clk);
		check(fl.busy, 1'b1, "program not running");
		req_abort = 1'b1;
		n = 0;
		while (flash_ctl.reset_n !== 1'b0 && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
		req_abort = 1'b0;
		check(n < 20, 1'b1, "no reset pulse");
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		check(fl.busy, 1'b0, "program not aborted");
		do_req(1'b0, 21'h0F0F0F, 16'h0000, 1'b0);
		check(q, 16'hFFFF, "aborted word written");
	endtask
	// a device stuck past the bound: host must time out and pulse reset
	task automatic t_timeout;
		fl.prog_ns = 12000;
		do_req(1'b1, 21'h054321, 16'h1234, 1'b0);
		check(prog_timeout, 1'b1, "no timeout");
		check(flash_ctl.reset_n, 1'b0, "no reset pulse on timeout");
		check(fl.busy, 1'b0, "program survived reset");
		fl.prog_ns = fl.PROG_NS;
		do_req(1'b0, 21'h054321, 16'h0000, 1'b0);
		check(prog_timeout, 1'b0, "timeout not cleared");
		check(q, 16'hFFFF, "timed-out word written");
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk) reset = 1'b0;
		check({11'h000, flash_ctl}, 16'h001F, "pins after reset");
		do_req(1'b0, 21'h012345, 16'h0000, 1'b1);
		check(q, 16'hFFFF, "erased read");
		check(fl.low_pwr, 1'b1, "no low power after read");
		t_program(21'h1ABCDE, 16'h5A3C);
		t_program(21'h1ABCDF, 16'hC3A5);
		fl.wipe(21'h1ABCDE, 1'b0);
		do_req(1'b0, 21'h1ABCDF, 16'h0000, 1'b0);
		check(q, 16'hFFFF, "sector not erased");
		t_program(21'h1ABCDE, 16'h0F3C);
		t_protect();
		t_timeout();
		t_abort();
		finish_test();
	end
	// hang guard, far beyond the expected run of about 1200 cycles
	initial begin
		#400000;
		n_errors++;
		finish_test();
	end
endmodule

// file: tb/pfwp_flash_model.sv
// behavioural flash device on the host's pins: read, unlock and word program
// assumes the bench resolves the data pins and feeds them back as pins
`timescale 1ns/1ps
module pfwp_flash_model #(
	parameter int PROG_NS = 2000
) (
	// pins from the host
	input wire logic [20:0] addr,
	input wire pfwp_pkg::pfwp_ctl_t ctl,
	input wire logic [15:0] pins,
	// data toward the host
	output logic [15:0] dout
);
	logic [15:0] mem [int];
	logic [20:0] lat_a, prog_a;
	logic [15:0] pdata, rd_v, hold_v;
	logic [1:0] step;
	logic busy, tog, wr_on, drive, low_pwr, pwr_hold;
	int n_wr, n_bad, n_prog, prog_ns;
	event go;
	initial begin
		{step, busy, tog, wr_on, n_wr, n_bad, n_prog} = '0;
		hold_v = 16'hA5C3;
		low_pwr = 1'b0;
		pwr_hold = 1'b1;
		prog_ns = PROG_NS;
	end
	// drives read data only when selected, gated and out of reset
	assign drive = !ctl.chip_sel_n && !ctl.out_gate_n &&
		ctl.reset_n;
	// status only while programming; erased words read all ones
	always @* begin
		if (busy) begin
			rd_v = {pdata[15:8], ~pdata[7], tog, pdata[5:0]};
		end else begin
			// an erased word has its polling bit set
			rd_v = mem.exists(addr) ? mem[addr] : 16'hFFFF;
		end
	end
	// released pins show a stale inverse so a sloppy sample cannot pass
	assign dout = drive ? rd_v : hold_v;
	always @(negedge drive) begin
		hold_v = ~rd_v;
		if (busy) tog = ~tog;
		if (!pwr_hold) low_pwr = 1'b1;
	end
	// a new read wakes it; data path untouched, so no added latency
	always @(posedge drive) low_pwr = 1'b0;
	// held awake from power-up until the address moves or select rises
	always @(addr or posedge ctl.chip_sel_n) begin
		low_pwr = 1'b0;
		pwr_hold = 1'b0;
	end
	// backdoor erase of a sector or block back to all ones
	task automatic wipe(input logic [20:0] a, input logic blk);
		int q[$];
		foreach (mem[k]) begin
			if (blk ? (k[20:15] == a[20:15]) :
				(k[20:11] == a[20:11])) q.push_back(k);
		end
		foreach (q[i]) mem.delete(q[i]);
	endtask
	// address on the later falling edge of strobe or select
	always @(negedge ctl.wr_strobe_n or negedge ctl.chip_sel_n) begin
		if (!ctl.wr_strobe_n && !ctl.chip_sel_n && ctl.reset_n) begin
			lat_a = addr;
			wr_on = 1'b1;
		end
	end
	// data on the earlier rising edge; ignored while busy
	always @(posedge ctl.wr_strobe_n or posedge ctl.chip_sel_n) begin
		if (wr_on) begin
			wr_on = 1'b0;
			n_wr++;
			if (!busy) take_cmd(lat_a, pins);
		end
	end
	task automatic take_cmd(input logic [20:0] a, input logic [15:0] d);
		logic ok;
		ok = 1'b1;
		case (step)
			2'h0: ok = (a == pfwp_pkg::UNLOCK_A1 && d == pfwp_pkg::UNLOCK_D1);
			2'h1: ok = (a == pfwp_pkg::UNLOCK_A2 && d == pfwp_pkg::UNLOCK_D2);
			2'h2: ok = (a == pfwp_pkg::UNLOCK_A1 && d == pfwp_pkg::PROG_CMD);
			default: begin
				// boot blocks are the two end blocks, picked by a[20:15]
				if (ctl.wr_prot_n ||
					(a[20:15] != 6'h00 && a[20:15] != 6'h3F)) begin
					// programming a word that is not erased is a host fault
					if (mem.exists(a) && mem[a] != 16'hFFFF) n_bad++;
					prog_a = a;
					pdata = d;
					busy = 1'b1;
					n_prog++;
					->go;
				end
			end
		endcase
		if (!ok) n_bad++;
		step = ok ? step + 2'h1 : 2'h0;
	endtask
	// each start gets its own timer; one left from an aborted start is dropped
	always @(go) begin
		fork
			run_prog(n_prog);
		join_none
	end
	task automatic run_prog(input int id);
		#(prog_ns);
		if (busy && id == n_prog) begin
			mem[prog_a] = pdata;
			busy = 1'b0;
		end
	endtask
	// reset pin abandons any program and the unlock state
	always @(negedge ctl.reset_n) begin
		busy = 1'b0;
		step = 2'h0;
		wr_on = 1'b0;
	end
endmodule
